// *** hdl/edops_ctrl.sv ***
// edops_ctrl: host-side page-mode controller with power-up wake-up and refresh
// Function
// - Reads and writes may mix within one row-open period at ordinary page speed.
// - After power-up wait at least 200 us, then issue at least eight row-strobe cycles.
// - The eight wake-up cycles are refresh cycles, row-only or column-first; the code issues column-first only.
// - If the refresh interval lapses, the eight-cycle wake-up is repeated first.
// - Column-first refresh: row strobe falls with a column strobe low; address ignored.
// - 1024 refresh cycles must be issued within each 16 ms window.
`timescale 1ns/1ns
module edops_ctrl #(
  parameter int unsigned PAUSE_CYCLES = edops_pkg::PAUSE_CYC,
  parameter int unsigned REFRESH_GAP  = edops_pkg::REF_GAP_CYC
) (
  // clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            rst_i,
  // user request
  input  wire logic                            req_valid_i,
  input  wire logic                            req_write_i,
  input  wire logic [1:0]                      req_byte_en_i,
  input  wire logic [edops_pkg::ADDR_W-1:0]    req_row_i,
  input  wire logic [edops_pkg::ADDR_W-1:0]    req_col_i,
  input  wire logic [edops_pkg::DATA_W-1:0]    req_wdata_i,
  output logic                                 req_ready_o,
  // user answer
  output logic                                 rsp_valid_o,
  output logic [edops_pkg::DATA_W-1:0]         rsp_rdata_o,
  output logic                                 init_done_o,
  // memory pins
  output logic                                 row_strobe_n_o,
  output logic                                 low_byte_column_strobe_n_o,
  output logic                                 high_byte_column_strobe_n_o,
  output logic                                 write_enable_n_o,
  output logic                                 output_enable_n_o,
  output logic [edops_pkg::ADDR_W-1:0]         mem_addr_o,
  input  wire logic [edops_pkg::DATA_W-1:0]    mem_data_i,
  output logic [edops_pkg::DATA_W-1:0]         mem_data_o,
  output logic [edops_pkg::DATA_W-1:0]         mem_data_oe_o
);
  import edops_pkg::*;

  edops_state_e              state;
  logic [CNT_W-1:0]          pause_cnt;
  logic [CNT_W-1:0]          ref_cnt;
  logic                      ref_due;
  logic                      ref_lapsed;
  logic [3:0]                phase;
  logic [3:0]                wake_cnt;
  logic                      waking;
  logic [ADDR_W-1:0]         open_row;
  logic                      cur_write;
  logic [1:0]                cur_be;
  logic                      take;
  logic [ADDR_W-1:0]         first_col;
  logic                      read_cap;

  // a page hit only for the open row; another row goes through precharge first
  assign take = (state == EDOPS_IDLE || (state == EDOPS_COLHI && req_row_i == open_row)) &&
                req_valid_i && !ref_due && !waking;

  // refresh interval timer: one refresh per gap keeps 1024 rows inside 16 ms
  always_ff @(posedge clock_i) begin
    if (rst_i || state == EDOPS_PAUSE) begin
      ref_cnt    <= '0;
      ref_due    <= 1'b0;
      ref_lapsed <= 1'b0;
    end else if (state == EDOPS_RCAS) begin
      ref_cnt    <= '0;
      ref_due    <= 1'b0;
      // a lapse in the same cycle wins over the clear
      ref_lapsed <= (ref_cnt == CNT_W'(2 * REFRESH_GAP - 1));
    end else begin
      ref_cnt <= ref_cnt + 1'b1;
      // raised early so the worst wait for the strobe still fits the gap
      if (ref_cnt == CNT_W'(REFRESH_GAP - 1 - REF_SLACK_CYC)) begin
        ref_due <= 1'b1;
      end
      if (ref_cnt == CNT_W'(2 * REFRESH_GAP - 1)) begin
        ref_lapsed <= 1'b1;
      end
    end
  end

  // wake-up bookkeeping
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wake_cnt <= WAKE_CNT_INIT;
      waking   <= 1'b1;
    end else if (ref_lapsed && !waking) begin
      wake_cnt <= WAKE_CNT_INIT;
      waking   <= 1'b1;
    end else if (state == EDOPS_RUP && phase == 4'h0 && waking) begin
      if (wake_cnt == WAKE_CNT_LAST) begin
        waking <= 1'b0;
      end
      wake_cnt <= wake_cnt + 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      init_done_o <= 1'b0;
    end else begin
      init_done_o <= !waking && state != EDOPS_PAUSE;
    end
  end

  // main sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state     <= EDOPS_PAUSE;
      pause_cnt <= '0;
      phase     <= 4'h0;
      open_row  <= '0;
      cur_write <= 1'b0;
      cur_be    <= 2'h0;
    end else begin
      if (phase != 4'h0) begin
        phase <= phase - 4'h1;
      end
      unique case (state)
        EDOPS_PAUSE: begin
          pause_cnt <= pause_cnt + 1'b1;
          if (pause_cnt == CNT_W'(PAUSE_CYCLES - 1)) begin
            state <= EDOPS_IDLE;
          end
        end
        EDOPS_IDLE: begin
          if (ref_due || waking) begin
            state <= EDOPS_RCAS;
          end else if (take) begin
            open_row  <= req_row_i;
            cur_write <= req_write_i;
            cur_be    <= req_byte_en_i;
            phase     <= ROW_LOW_CYC;
            state     <= EDOPS_ROW;
          end
        end
        EDOPS_ROW: begin
          if (phase == 4'h0) begin
            state <= EDOPS_COLSET;
          end
        end
        EDOPS_COLSET: state <= EDOPS_COL;
        EDOPS_COL:    state <= EDOPS_COLHI;
        EDOPS_COLHI: begin
          if (take && req_row_i == open_row) begin
            cur_write <= req_write_i;
            cur_be    <= req_byte_en_i;
            state     <= EDOPS_COLSET;
          end else if (req_valid_i || ref_due || waking) begin
            phase <= PRECHARGE_CYC;
            state <= EDOPS_PRE;
          end
        end
        EDOPS_PRE: begin
          if (phase == 4'h0) begin
            state <= EDOPS_IDLE;
          end
        end
        EDOPS_RCAS: begin
          phase <= REF_LOW_CYC;
          state <= EDOPS_RREF;
        end
        EDOPS_RREF: begin
          if (phase == 4'h0) begin
            phase <= PRECHARGE_CYC;
            state <= EDOPS_RUP;
          end
        end
        EDOPS_RUP: begin
          if (phase == 4'h0) begin
            state <= EDOPS_IDLE;
          end
        end
        default: state <= EDOPS_IDLE;
      endcase
    end
  end

  // pin drive, all registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      row_strobe_n_o              <= 1'b1;
      low_byte_column_strobe_n_o  <= 1'b1;
      high_byte_column_strobe_n_o <= 1'b1;
      write_enable_n_o            <= 1'b1;
      output_enable_n_o           <= 1'b1;
      mem_addr_o                  <= '0;
      mem_data_o                  <= '0;
      mem_data_oe_o               <= '0;
    end else begin
      row_strobe_n_o <= !(state == EDOPS_ROW || state == EDOPS_COLSET ||
                          state == EDOPS_COL || state == EDOPS_COLHI ||
                          state == EDOPS_RREF);
      // column strobes low before row falls: column-first refresh
      low_byte_column_strobe_n_o  <= !((state == EDOPS_COL && cur_be[0]) ||
                                       state == EDOPS_RCAS || state == EDOPS_RREF);
      high_byte_column_strobe_n_o <= !((state == EDOPS_COL && cur_be[1]) ||
                                       state == EDOPS_RCAS || state == EDOPS_RREF);
      write_enable_n_o  <= !(cur_write && (state == EDOPS_COLSET || state == EDOPS_COL));
      // released at the same edge at which a write starts driving the data pins
      output_enable_n_o <= (take && req_write_i) ||
                           !(!cur_write && state != EDOPS_RCAS && state != EDOPS_RREF &&
                             row_strobe_n_o == 1'b0);
      if (state == EDOPS_IDLE && take) begin
        mem_addr_o <= req_row_i;
      end else if ((state == EDOPS_ROW && phase == 4'h0) ||
                   (state == EDOPS_COLHI && take)) begin
        mem_addr_o <= (state == EDOPS_COLHI) ? req_col_i : first_col;
      end else if (state == EDOPS_RCAS) begin
        mem_addr_o <= '0;
      end
      if (take) begin
        mem_data_o <= req_wdata_i;
      end
      mem_data_oe_o <= (req_write_i && take) ?
                       {{BYTE_W{req_byte_en_i[1]}}, {BYTE_W{req_byte_en_i[0]}}} :
                       (state == EDOPS_ROW || state == EDOPS_COLSET ||
                        state == EDOPS_COL) ? mem_data_oe_o : '0;
    end
  end

  // column address for first access, held from the request
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      first_col <= '0;
    end else if (state == EDOPS_IDLE && take) begin
      first_col <= req_col_i;
    end
  end

  // read capture: data stays valid after strobe rises, so sample in COLHI
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      read_cap    <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      req_ready_o <= 1'b0;
    end else begin
      // one answer per read strobe, even while the page stays open
      read_cap    <= (state == EDOPS_COL) && !cur_write;
      rsp_valid_o <= read_cap;
      if (read_cap) begin
        rsp_rdata_o <= mem_data_i;
      end
      req_ready_o <= take;
    end
  end
endmodule

// *** hdl/edops_pkg.sv ***
// package: constants for the page-mode memory controller
package edops_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned PAUSE_US       = 200;
  localparam int unsigned PAUSE_CYC      = PAUSE_US * CLK_MHZ;
  localparam int unsigned REF_WIN_MS     = 16;
  localparam int unsigned REF_ROWS       = 1024;
  // per-row spacing, rounded down so the window is never exceeded
  localparam int unsigned REF_GAP_CYC    = (REF_WIN_MS * 1000 * CLK_MHZ) / REF_ROWS;
  // worst wait from refresh request to its strobe, taken off the gap
  localparam int unsigned REF_SLACK_CYC  = 16;
  localparam int unsigned WAKE_CYCLES    = 8;
  localparam int unsigned ADDR_W         = 10;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned CNT_W          = 24;
  // strobe phase lengths in clock cycles (40 ns each)
  localparam logic [3:0]  ROW_LOW_CYC    = 4'h2;
  localparam logic [3:0]  PRECHARGE_CYC  = 4'h1;
  localparam logic [3:0]  REF_LOW_CYC    = 4'h2;
  localparam logic [3:0]  WAKE_CNT_INIT  = 4'h0;
  localparam logic [3:0]  WAKE_CNT_LAST  = 4'h7;

  typedef enum logic [3:0] {
    EDOPS_PAUSE  = 4'h0,
    EDOPS_IDLE   = 4'h1,
    EDOPS_ROW    = 4'h3,
    EDOPS_COLSET = 4'h2,
    EDOPS_COL    = 4'h6,
    EDOPS_COLHI  = 4'h7,
    EDOPS_PRE    = 4'h5,
    EDOPS_RCAS   = 4'h4,
    EDOPS_RREF   = 4'hc,
    EDOPS_RUP    = 4'hd
  } edops_state_e;
endpackage

// *** tb/edops_ctrl_asserts.sv ***
// checker: timing properties at the page-mode controller ports
`timescale 1ns/1ns
module edops_ctrl_asserts #(
  parameter int unsigned PAUSE_CYCLES = 20,
  parameter int unsigned REFRESH_GAP  = 40
) (
  input wire logic clock_i, rst_i, init_done_o, output_enable_n_o, write_enable_n_o,
  input wire logic row_strobe_n_o, low_byte_column_strobe_n_o, high_byte_column_strobe_n_o,
  input wire logic [edops_pkg::DATA_W-1:0] mem_data_oe_o
);
  wire ras = row_strobe_n_o;
  wire lo = low_byte_column_strobe_n_o;
  wire hi = high_byte_column_strobe_n_o;
  wire wr = !ras && !write_enable_n_o;
  logic [3:0] wk;
  int unsigned up, gap;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // row falls counted while waking
  always_ff @(posedge clock_i) begin
    if (rst_i || init_done_o) wk <= 4'h0;
    else if ($fell(ras) && wk != 4'hf) wk <= wk + 4'h1;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) up <= 0;
    else if (up < PAUSE_CYCLES) up <= up + 1;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i || ($fell(ras) && !(lo && hi))) gap <= 0;
    else gap <= gap + 1;
  end
  pause_quiet_a: assert property (up < PAUSE_CYCLES |-> ras)
    else $error("row strobe in pause");
  wake_count_a: assert property ($rose(init_done_o) |-> wk >= 4'h8)
    else $error("short wake-up");
  wake_kind_a: assert property ($fell(ras) && !init_done_o |-> !(lo && hi))
    else $error("wake cycle not refresh");
  refresh_hiz_a: assert property ($fell(ras) && !($past(lo) && $past(hi)) |-> (mem_data_oe_o == '0) [*2])
    else $error("driving in refresh");
  refresh_gap_a: assert property (init_done_o |-> gap < REFRESH_GAP)
    else $error("refresh late");
  low_write_a: assert property ($fell(lo) && wr |-> mem_data_oe_o[7:0] == 8'hff)
    else $error("low byte not driven");
  high_write_a: assert property ($fell(hi) && wr |-> mem_data_oe_o[15:8] == 8'hff)
    else $error("high byte not driven");
  read_quiet_a: assert property (!ras && !output_enable_n_o && write_enable_n_o |-> mem_data_oe_o == '0)
    else $error("driving in read");
  cover property ($rose(init_done_o));
  cover property ($fell(lo) && wr);
  cover property ($fell(hi) && !ras && !output_enable_n_o);
endmodule
bind edops_ctrl edops_ctrl_asserts #(.PAUSE_CYCLES(PAUSE_CYCLES), .REFRESH_GAP(REFRESH_GAP))
  edops_ctrl_asserts_i (.clock_i(clock_i), .rst_i(rst_i), .init_done_o(init_done_o),
  .output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
  .row_strobe_n_o(row_strobe_n_o), .low_byte_column_strobe_n_o(low_byte_column_strobe_n_o),
  .high_byte_column_strobe_n_o(high_byte_column_strobe_n_o), .mem_data_oe_o(mem_data_oe_o));

// *** tb/edops_mem_model.sv ***
// model: page-mode memory device seen from its pins
`timescale 1ns/1ns
module edops_mem_model (
  input  wire logic        ras_n_i, lo_n_i, hi_n_i, we_n_i, oe_n_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output int               refresh_o
);
  logic [15:0] mem [logic [19:0]];
  logic [9:0]  row;
  logic [19:0] k;
  initial rdata_o = 16'h5a5a;
  initial refresh_o = 0;
  always @(negedge ras_n_i)
    if (!lo_n_i || !hi_n_i) refresh_o++;
    else row = addr_i;
  // released bus shows the inverse of the last value
  always @(posedge ras_n_i) rdata_o = ~rdata_o;
  always @(negedge lo_n_i or negedge hi_n_i) begin
    k = {row, addr_i};
    if (!mem.exists(k)) mem[k] = 16'h0;
    if (!ras_n_i && !we_n_i) begin
      if (!lo_n_i) mem[k][7:0] = wdata_i[7:0];
      if (!hi_n_i) mem[k][15:8] = wdata_i[15:8];
      rdata_o = ~wdata_i;
    end else if (!ras_n_i && !oe_n_i) rdata_o = mem[k];
  end
endmodule

// *** tb/test_edo_page_and_power_on_seq.sv ***
// bench: page-mode controller against a pin-level memory model
`timescale 1ns/1ns
module test_edo_page_and_power_on_seq;
  import edops_pkg::*;
  logic clock_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0;
  logic [1:0] req_byte_en_i = 0;
  logic [ADDR_W-1:0] req_row_i = 0, req_col_i = 0, mem_addr_o, r0;
  logic [DATA_W-1:0] req_wdata_i = 0, mem_data_i, mem_data_o, mem_data_oe_o, rsp_rdata_o, q;
  logic req_ready_o, rsp_valid_o, init_done_o, row_strobe_n_o, write_enable_n_o;
  logic low_byte_column_strobe_n_o, high_byte_column_strobe_n_o, output_enable_n_o;
  logic [DATA_W-1:0] shadow [logic [19:0]];
  logic [DATA_W-1:0] expq [$];
  int n_errors = 0, check_count = 0, refreshes, i, snap;
  always #20 clock_i = ~clock_i;
  edops_ctrl #(.PAUSE_CYCLES(20), .REFRESH_GAP(40)) edops_ctrl_i (.*);
  assign mem_data_i = (mem_data_oe_o & mem_data_o) | (~mem_data_oe_o & q);
  edops_mem_model edops_mem_model_i (.ras_n_i(row_strobe_n_o),
    .lo_n_i(low_byte_column_strobe_n_o), .hi_n_i(high_byte_column_strobe_n_o),
    .we_n_i(write_enable_n_o), .oe_n_i(output_enable_n_o), .addr_i(mem_addr_o),
    .wdata_i(mem_data_i), .rdata_o(q), .refresh_o(refreshes));
  task automatic check_val(input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    for (k = 0; k < lim && s !== 1'b1; k++) @(posedge clock_i) #1;
    if (s !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic access(input logic w, input logic [1:0] be, input logic [9:0] r, c,
                        input logic [15:0] d);
    @(posedge clock_i);
    {req_valid_i, req_write_i, req_byte_en_i, req_row_i, req_col_i, req_wdata_i} <=
      {1'b1, w, be, r, c, d};
    if (!shadow.exists({r, c})) shadow[{r, c}] = 16'h0;
    for (int b = 0; b < 2; b++) if (w && be[b]) shadow[{r, c}][8*b +: 8] = d[8*b +: 8];
    if (!w) expq.push_back(shadow[{r, c}]);
    @(posedge clock_i) #1;
    wait_hi(req_ready_o, 400);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask
  // compares each read answer with the oldest note
  always @(posedge clock_i) if (rsp_valid_o === 1'b1) begin
    if (expq.size() == 0) check_val(~rsp_rdata_o, rsp_rdata_o);
    else check_val(expq.pop_front(), rsp_rdata_o);
  end
  initial begin
    snap = $urandom(32'h1399d252);
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    wait_hi(init_done_o, 600);
    check_val(16'(refreshes >= 8), 16'h1);
    $display("test wake-up done");
    r0 = 10'($urandom_range(1023));
    for (i = 0; i < 24; i++)
      access(i < 8 || $urandom_range(1), 2'b11, r0,
             10'(1023 - (i < 8 ? i : $urandom_range(7)) * 146), 16'($urandom));
    $display("test page mix done");
    for (i = 1; i < 4; i++) begin
      access(1'b1, 2'(i), r0 ^ 10'h1, 10'h0, 16'($urandom));
      access(1'b0, 2'b11, r0 ^ 10'h1, 10'h0, 16'h0);
    end
    $display("test byte lanes done");
    snap = refreshes;
    repeat (400) @(posedge clock_i);
    check_val(16'(refreshes - snap >= 10), 16'h1);
    access(1'b0, 2'b11, r0, 10'h3ff, 16'h0);
    for (i = 0; i < 50 && expq.size() > 0; i++) @(posedge clock_i);
    check_val(16'(expq.size()), 16'h0);
    $display("test refresh done");
    report_and_stop();
  end
endmodule
